// ==== rtl/cmc_pkg.sv ====
// Purpose: Shared constants and carriers for the channel control block
// Assumes: 16 streams, up to 128 channels, one master clock
// Notes: Connection word field positions and rate codes live here
package cmc_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_STREAMS = 16;
    localparam int unsigned MAX_CHANNELS = 128;
    localparam int unsigned CM_DEPTH = NUM_STREAMS * MAX_CHANNELS;
    localparam int unsigned CM_AW = 11;
    localparam int unsigned OFS_MAX_HALF = 9;   // 4.5 periods in halves
    // ------------------------------------------------------------
    // Connection word fields
    // ------------------------------------------------------------
    localparam int unsigned BIT_LOOPBACK = 15;
    localparam int unsigned BIT_CONSTANT = 14;
    localparam int unsigned BIT_MESSAGE = 13;
    localparam int unsigned BIT_CONTROL = 12;
    localparam int unsigned BIT_ENABLE = 11;
    localparam int unsigned STREAM_HI = 10;
    localparam int unsigned STREAM_LO = 7;
    localparam int unsigned CHAN_HI = 6;
    localparam int unsigned CHAN_LO = 0;
    localparam int unsigned MSG_HI = 7;
    localparam int unsigned FILL_LO = 11;
    localparam logic [15:0] CM_RESET = 16'h0000;
    // ------------------------------------------------------------
    // Rate select codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMC_RATE_2M = 2'b00,
        CMC_RATE_4M = 2'b01,
        CMC_RATE_8M = 2'b10,
        CMC_RATE_RSV = 2'b11
    } cmc_rate_e;
    // Decoded connection word
    typedef struct packed {
        logic channel_loopback;
        logic constant_delay;
        logic message_select;
        logic control_bit;
        logic output_enable;
        logic [3:0] source_stream_field;
        logic [6:0] source_channel_field;
    } cmc_word_s;
    // Per stream offset setting
    typedef struct packed {
        logic [2:0] whole;
        logic half_period_enable;
    } cmc_offset_s;
endpackage : cmc_pkg

// ==== rtl/cmc_channel_control.sv ====
// Purpose: Connection memory, per channel decode and input offset control
// Assumes: Host port is synchronous; channel timing supplied by framer
// Notes: Data memory itself is outside; this block issues its address
//
// What this block does
// - Report whole delay with flag set; 0 adds half
// - Shift sampling by offset plus optional half
// - Loopback takes input from same output slot
// - Bit 14 selects constant over variable delay
// - Message bit outputs low connection byte
// - Otherwise word addresses switched input data
// - Control bit output one channel early
// - Bit 11 enables per channel output driver
// - Source stream from bits ten to seven
// - Source channel from bits six to zero
// - Channel field width follows data rate
// - Rate code picks frame length; 11 reserved
// - Channel enable acts after global release
// - Block fill sets top five, clears rest
`timescale 1ns/1ps
module cmc_channel_control (
    input wire logic clk_in,
    input wire logic rst_in,
    // Host access to connection memory
    input wire logic host_wr_in,
    input wire logic [10:0] host_addr_in,
    input wire logic [15:0] host_wdata_in,
    output logic [15:0] host_rdata_out,
    // Block programming
    input wire logic block_start_in,
    input wire logic [4:0] block_fill_value_in,
    output logic block_busy_out,
    // Global controls
    input wire logic [1:0] rate_select_in,
    input wire logic global_drive_pin_in,
    input wire logic standby_release_bit_in,
    // Output slot timing from framer
    input wire logic slot_tick_in,
    input wire logic [3:0] out_stream_in,
    input wire logic [6:0] out_channel_in,
    // Data memory interface
    output logic [10:0] dm_addr_out,
    output logic dm_constant_out,
    input wire logic [7:0] dm_data_in,
    output logic [7:0] serial_out_data_out,
    output logic serial_out_oe_n_out,
    output logic control_serial_out,
    output logic channel_loopback_out,
    // Offset programming and measurement
    input wire logic [1:0] half_period_flag_in,
    input wire logic [2:0] measured_whole_delay_in,
    output logic [3:0] measured_half_count_out,
    input wire logic ofs_wr_in,
    input wire logic [3:0] ofs_stream_in,
    input wire logic [3:0] ofs_value_in,
    input wire logic [3:0] sample_stream_in,
    output logic [3:0] sample_delay_halves_out
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] cm_mem [0:cmc_pkg::CM_DEPTH-1]; // Connection words
    cmc_pkg::cmc_offset_s ofs_q [0:cmc_pkg::NUM_STREAMS-1];
    logic [10:0] fill_ptr_q;      // Block fill pointer
    logic fill_active_q;          // Block fill running
    logic [15:0] word_q;          // Word read for current slot
    logic [15:0] early_q;         // Word for the next slot
    logic [15:0] rdata_q;         // Host read data
    logic [7:0] data_q;           // Output byte
    logic oe_n_q;                 // Output disable
    logic cst_q;                  // Control output
    logic [3:0] half_q;           // Sample shift in halves

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    cmc_pkg::cmc_word_s cur;
    assign cur = cmc_pkg::cmc_word_s'(word_q);
    // Channel mask per rate; reserved code treated as widest
    wire [6:0] chan_mask = (rate_select_in == cmc_pkg::CMC_RATE_2M) ?
        7'h1f : (rate_select_in == cmc_pkg::CMC_RATE_4M) ?
        7'h3f : 7'h7f;
    wire [10:0] slot_addr = {out_stream_in, out_channel_in & chan_mask};
    // Next slot address, wrapping inside the active frame
    wire [6:0] next_chan = (out_channel_in + 7'h01) & chan_mask;
    wire [3:0] next_strm = (next_chan == 7'h00) ?
        out_stream_in + 4'h1 : out_stream_in;
    wire [10:0] next_addr = {next_strm, next_chan};
    wire global_release = global_drive_pin_in | standby_release_bit_in;
    wire [15:0] fill_word = {block_fill_value_in, 11'h000};
    wire [10:0] src_addr = {cur.source_stream_field,
        cur.source_channel_field & chan_mask};
    // Loopback sources the same slot's own output location
    wire [10:0] dm_sel = cur.channel_loopback ? slot_addr : src_addr;

    // ------------------------------------------------------------
    // Memory write port: host or block fill
    // ------------------------------------------------------------
    // Fill walks every word one per clock; host writes during the fill are dropped
    always_ff @(posedge clk_in)
    begin
        if (fill_active_q)
            cm_mem[fill_ptr_q] <= fill_word;
        else if (host_wr_in)
            cm_mem[host_addr_in] <= host_wdata_in;
    end

    // Fill sequencer
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            fill_active_q <= 1'b0;
            fill_ptr_q <= 11'h000;
        end
        else if (fill_active_q)
        begin
            fill_ptr_q <= fill_ptr_q + 11'h001;
            fill_active_q <= (fill_ptr_q != 11'h7ff);
        end
        else if (block_start_in)
        begin
            fill_active_q <= 1'b1;
            fill_ptr_q <= 11'h000;
        end
    end

    // ------------------------------------------------------------
    // Slot read and output path
    // ------------------------------------------------------------
    // Two reads per slot; next word prefetched for the early control bit
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            word_q <= cmc_pkg::CM_RESET;
            early_q <= cmc_pkg::CM_RESET;
            cst_q <= 1'b0;
        end
        else if (slot_tick_in)
        begin
            word_q <= cm_mem[slot_addr];
            early_q <= cm_mem[next_addr];
            cst_q <= cm_mem[next_addr][cmc_pkg::BIT_CONTROL];
        end
    end

    // Output byte and driver enable, one cycle after the word
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            data_q <= 8'h00;
            oe_n_q <= 1'b1;
        end
        else
        begin
            if (cur.message_select)
                data_q <= word_q[cmc_pkg::MSG_HI:0];
            else
                data_q <= dm_data_in;
            // Global hold wins until released
            oe_n_q <= ~(global_release &
                cur.output_enable);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rdata_q <= 16'h0000;
        else
            rdata_q <= cm_mem[host_addr_in];
    end

    // ------------------------------------------------------------
    // Offset registers and measurement mapping
    // ------------------------------------------------------------
    // Flag high means whole count; low adds one half period
    wire [3:0] meas_halves = {measured_whole_delay_in, 1'b0} +
        {3'h0, ~half_period_flag_in[0]};
    wire [3:0] cfg_halves = {ofs_q[sample_stream_in].whole, 1'b0} +
        {3'h0, ofs_q[sample_stream_in].half_period_enable};

    genvar gi;
    generate
        for (gi = 0; gi < cmc_pkg::NUM_STREAMS; gi++)
        begin : g_ofs
            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                    ofs_q[gi] <= '0;
                else if (ofs_wr_in && ofs_stream_in == 4'(gi))
                    ofs_q[gi] <= cmc_pkg::cmc_offset_s'(ofs_value_in);
            end
        end
    endgenerate

    // Clamp to the largest supported shift
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            half_q <= 4'h0;
        else if (cfg_halves > 4'(cmc_pkg::OFS_MAX_HALF))
            half_q <= 4'(cmc_pkg::OFS_MAX_HALF);
        else
            half_q <= cfg_halves;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign host_rdata_out = rdata_q;
    assign block_busy_out = fill_active_q;
    assign dm_addr_out = dm_sel;
    assign dm_constant_out = cur.constant_delay;
    assign channel_loopback_out = cur.channel_loopback;
    assign serial_out_data_out = data_q;
    assign serial_out_oe_n_out = oe_n_q;
    assign control_serial_out = cst_q;
    assign measured_half_count_out = meas_halves;
    assign sample_delay_halves_out = half_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fill_start;
        !fill_active_q && block_start_in;
    endsequence
    AST_FILL_RUNS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_fill_start |=> fill_active_q [*8])
        else $error("Block fill did not start");
    AST_MSG_BYTE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        cur.message_select |=> data_q == $past(word_q[7:0]))
        else $error("Message byte not output");
    AST_SW_BYTE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !cur.message_select |=> data_q == $past(dm_data_in))
        else $error("Switched byte not output");
    AST_OE_HOLD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !global_release |=> serial_out_oe_n_out)
        else $error("Driver on before release");
    AST_OE_BIT: assert property (
        @(posedge clk_in) disable iff (rst_in)
        global_release && !cur.output_enable |=> oe_n_q)
        else $error("Driver on with enable low");
    // Loopback must point at the stream now being output
    AST_LOOP_ADDR: assert property (
        @(posedge clk_in) disable iff (rst_in)
        cur.channel_loopback |-> dm_addr_out[10:7] == out_stream_in)
        else $error("Loopback address wrong");
    AST_SRC_ADDR: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !cur.channel_loopback |-> dm_addr_out[10:7] == word_q[10:7])
        else $error("Source stream wrong");
    AST_CHAN_MASK: assert property (
        @(posedge clk_in) disable iff (rst_in)
        rate_select_in == 2'b00 |-> dm_addr_out[6:5] == 2'b00)
        else $error("Channel field not masked");
    AST_SHIFT_MAX: assert property (
        @(posedge clk_in) disable iff (rst_in)
        ##1 half_q <= 4'h9)
        else $error("Shift above limit");
    AST_MEAS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        half_period_flag_in[0] |-> !measured_half_count_out[0])
        else $error("Whole delay has half");
    AST_CST_EARLY: assert property (
        @(posedge clk_in) disable iff (rst_in)
        slot_tick_in |=> cst_q == early_q[12])
        else $error("Control bit not early");
    AST_VC: assert property (
        @(posedge clk_in) disable iff (rst_in)
        dm_constant_out == word_q[14])
        else $error("Delay mode wrong");
endmodule // cmc_channel_control

// ==== tb/cmc_dm_model.sv ====
// Purpose: Data memory stand-in answering the switched read port
// Assumes: The byte depends only on the address presented
// Notes: The hash mixes stream bits so a wrong address shows up
`timescale 1ns/1ps
module cmc_dm_model (
    input wire logic [10:0] addr_in,
    output logic [7:0] data_out
);
    // Hash in place of storage keeps the model small and always valid
    assign data_out = addr_in[7:0] ^ {1'b0, addr_in[10:4]};
endmodule // cmc_dm_model

// ==== tb/test_connection_memory_channel_control.sv ====
// Purpose: Self-checking bench for the channel control block
// Assumes: Inputs change on the falling clock edge only
// Notes: Control serial output is checked against the next slot's word
`timescale 1ns/1ps
module test_connection_memory_channel_control;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_in, rst_in, host_wr_in, block_start_in, block_busy_out;
    logic global_drive_pin_in, standby_release_bit_in, slot_tick_in;
    logic dm_constant_out, serial_out_oe_n_out, control_serial_out;
    logic channel_loopback_out, ofs_wr_in;
    logic [1:0] rate_select_in, half_period_flag_in;
    logic [2:0] measured_whole_delay_in;
    logic [3:0] out_stream_in, measured_half_count_out, ofs_stream_in;
    logic [3:0] ofs_value_in, sample_stream_in, sample_delay_halves_out;
    logic [4:0] block_fill_value_in;
    logic [6:0] out_channel_in, c, nc;
    logic [7:0] dm_data_in, serial_out_data_out;
    logic [10:0] host_addr_in, dm_addr_out, ea;
    logic [15:0] host_wdata_in, host_rdata_out, w, rd, nw;
    int errors = 0;
    int num_checks = 0;
    cmc_channel_control uut (.clk_in, .rst_in, .host_wr_in, .host_addr_in,
        .host_wdata_in, .host_rdata_out, .block_start_in,
        .block_fill_value_in, .block_busy_out, .rate_select_in,
        .global_drive_pin_in, .standby_release_bit_in, .slot_tick_in,
        .out_stream_in, .out_channel_in, .dm_addr_out, .dm_constant_out,
        .dm_data_in, .serial_out_data_out, .serial_out_oe_n_out,
        .control_serial_out, .channel_loopback_out, .half_period_flag_in,
        .measured_whole_delay_in, .measured_half_count_out, .ofs_wr_in,
        .ofs_stream_in, .ofs_value_in, .sample_stream_in,
        .sample_delay_halves_out);
    // Far side data memory
    cmc_dm_model dm (.addr_in(dm_addr_out), .data_out(dm_data_in));
    // 100 MHz clock
    always #5 clk_in = ~clk_in;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One write cycle, strobe dropped at the next falling edge
    task automatic host_write(input logic [10:0] a, input logic [15:0] d);
        host_addr_in = a;
        host_wdata_in = d;
        host_wr_in = 1'b1;
        @(negedge clk_in);
        host_wr_in = 1'b0;
    endtask
    // Registered read, valid one edge after the address
    task automatic host_read(input logic [10:0] a, output logic [15:0] d);
        host_addr_in = a;
        @(negedge clk_in);
        d = host_rdata_out;
    endtask
    // Slot tick, then one edge for the registered byte and enable
    task automatic slot(input logic [3:0] s, input logic [6:0] ch);
        out_stream_in = s;
        out_channel_in = ch;
        slot_tick_in = 1'b1;
        @(negedge clk_in);
        slot_tick_in = 1'b0;
        @(negedge clk_in);
    endtask
    // Channel bits in use at each rate; reserved code acts as top rate
    function automatic logic [6:0] chan_mask(input logic [1:0] r);
        return (r == 2'b00) ? 7'h1f : (r == 2'b01) ? 7'h3f : 7'h7f;
    endfunction
    function automatic logic [7:0] dm_byte(input logic [10:0] a);
        return a[7:0] ^ {1'b0, a[10:4]};
    endfunction
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run of some 2350 cycles
    initial
    begin
        #400us;
        errors++;
        test_done();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {clk_in, host_wr_in, block_start_in, slot_tick_in, ofs_wr_in} = '0;
        rst_in = 1'b1;
        {global_drive_pin_in, standby_release_bit_in} = 2'b00;
        {rate_select_in, half_period_flag_in, measured_whole_delay_in} = '0;
        {out_stream_in, out_channel_in, host_addr_in, host_wdata_in} = '0;
        {ofs_stream_in, ofs_value_in, sample_stream_in} = '0;
        block_fill_value_in = '0;
        void'($urandom(32'h71cf47c9));
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        check("oe_n", 16'(serial_out_oe_n_out), 16'h0001);
        check("busy", 16'(block_busy_out), 16'h0000);
        check("halves", 16'(sample_delay_halves_out), 16'h0000);
        $display("test reset done");
        // Random words at every rate code, first one at the top slot
        for (int r = 0; r < 4; r++)
        begin
            rate_select_in = 2'(r);
            for (int i = 0; i < 12; i++)
            begin
                w = 16'($urandom);
                c = (i == 0) ? 7'h7f : 7'($urandom);
                c = c & chan_mask(rate_select_in);
                w[6:0] = w[6:0] & chan_mask(rate_select_in);
                global_drive_pin_in = 1'($urandom);
                standby_release_bit_in = 1'($urandom);
                out_stream_in = (i == 0) ? 4'hf : 4'($urandom);
                host_write({out_stream_in, c}, w);
                host_read({out_stream_in, c}, rd);
                check("word", rd, w);
                // Next slot word, so the early control bit is known
                nw = 16'($urandom);
                nc = (c + 7'h01) & chan_mask(rate_select_in);
                host_write({out_stream_in + 4'(nc == 7'h00), nc}, nw);
                slot(out_stream_in, c);
                ea = w[15] ? {out_stream_in, c} : w[10:0];
                check("dm_addr", 16'(dm_addr_out),
                    16'(ea));
                check("constant", 16'(dm_constant_out),
                    16'(w[14]));
                check("loopback", 16'(channel_loopback_out),
                    16'(w[15]));
                check("data", 16'(serial_out_data_out),
                    16'(w[13] ? w[7:0] : dm_byte(ea)));
                // Inverse taken at one bit, before widening
                check("oe_n", 16'(serial_out_oe_n_out), {15'h0000,
                    ~(w[11] & (global_drive_pin_in |
                    standby_release_bit_in))});
                check("cst", {15'h0000, control_serial_out},
                    {15'h0000, nw[12]});
            end
        end
        $display("test slots done");
        // Every measurement result, programmed back as software would
        for (int i = 0; i < 16; i++)
        begin
            half_period_flag_in = {1'b0, 1'(i >> 3)};
            measured_whole_delay_in = 3'(i);
            ofs_stream_in = 4'($urandom);
            sample_stream_in = ofs_stream_in;
            ofs_value_in = {measured_whole_delay_in,
                ~half_period_flag_in[0]};
            ofs_wr_in = 1'b1;
            @(negedge clk_in);
            ofs_wr_in = 1'b0;
            check("measured", 16'(measured_half_count_out),
                16'(ofs_value_in));
            repeat (2) @(negedge clk_in);
            check("halves", 16'(sample_delay_halves_out),
                16'((ofs_value_in > 4'h9) ? 4'h9 : ofs_value_in));
        end
        $display("test offsets done");
        // Block fill with a write attempted while it runs
        // Initialisation fill keeps loopback clear
        block_fill_value_in = {1'b0, 4'($urandom)};
        block_start_in = 1'b1;
        @(negedge clk_in);
        block_start_in = 1'b0;
        check("busy", 16'(block_busy_out), 16'h0001);
        // Write behind the fill pointer; a leak would survive the fill
        @(negedge clk_in);
        host_write(11'h000, 16'h5a5a);
        for (int n = 0; n < 4000 && block_busy_out !== 1'b0; n++)
            @(negedge clk_in);
        check("busy", 16'(block_busy_out), 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            host_read((i == 0) ? 11'h000 : 11'($urandom), rd);
            check("fill", rd, {block_fill_value_in, 11'h000});
        end
        $display("test fill done");
        test_done();
    end
endmodule // test_connection_memory_channel_control
